// File: pmx_map.svh
// Offsets, field positions and reset values of the indirect extension register bank.
// Assumes a 16-bit clause-22 register port inside the same transceiver clock domain.
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

`define PMX_PORTAL_CTRL_ADDR 5'h0D
`define PMX_PORTAL_DATA_ADDR 5'h0E

`define PMX_DEV_LOW_POWER 5'h07
`define PMX_DEV_FRONT_END 5'h1B
`define PMX_DEV_QUALITY 5'h1C

`define PMX_REG_ADVERTISE 16'h003C
`define PMX_REG_PARTNER 16'h003D
`define PMX_REG_PULSE_CTRL 16'h0000
`define PMX_REG_QUALITY 16'h00AC

`define PMX_ADV_RW_MASK 16'h00FB
`define PMX_ADV_100_BIT 1
`define PMX_ADV_1000_BIT 2
`define PMX_ADV_RESET 16'h0000
`define PMX_PULSE_RESET 16'h0020
`define PMX_PULSE_LSB 4
`define PMX_PULSE_MSB 7
`define PMX_SQI_LSB 8
`define PMX_SQI_MSB 14
`define PMX_CTRL_RESET 16'h0000
`define PMX_PTR_RESET 16'h0000

`endif

// File: pmx_pkg.sv
// Types shared by the extension register bank and the testbench.
// Assumes the constants of pmx_map.svh are included where needed.
package pmx_pkg;

    typedef enum logic [1:0] {
        PMX_FN_ADDRESS = 2'h0,
        PMX_FN_DATA = 2'h1,
        PMX_FN_DATA_INC_RW = 2'h2,
        PMX_FN_DATA_INC_WR = 2'h3
    } pmx_func_t;

    typedef struct packed {
        pmx_func_t func;
        logic [8:0] reserved;
        logic [4:0] dev_sel;
    } pmx_access_ctrl_t;

    typedef struct packed {
        logic gig_capable;
        logic fast_capable;
    } pmx_partner_cap_t;

endpackage : pmx_pkg

// File: pmx_ptr_file.sv
// Address pointers of the 32 indirect extension devices, one 16-bit word each.
// Assumes the caller never requests a load and an increment in the same cycle.
`timescale 1ns/1ns
`include "pmx_map.svh"
module pmx_ptr_file (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] sel,
    input wire logic load,
    input wire logic [15:0] load_data,
    input wire logic incr,
    output logic [15:0] ptr
);
    logic [15:0] ptr_r [0:31];

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_ptr
            always_ff @(posedge clk) begin
                if (reset) begin
                    ptr_r[gi] <= `PMX_PTR_RESET;
                end else if (sel == 5'(gi)) begin
                    if (load) begin
                        ptr_r[gi] <= load_data;
                    end else if (incr) begin
                        ptr_r[gi] <= ptr_r[gi] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    assign ptr = ptr_r[sel];
endmodule : pmx_ptr_file

// File: pmx_ext_regs.sv
// Indirect extension registers behind the access control and address/data portals.
// Assumes the serial management engine, negotiation logic and receiver run on CORE_CLK.
`timescale 1ns/1ns
`include "pmx_map.svh"
module pmx_ext_regs (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [4:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RD_VALID,
    input wire logic LINK_UP,
    input wire logic AN_EEE_VALID,
    input wire pmx_pkg::pmx_partner_cap_t AN_EEE_CAP,
    input wire logic [6:0] SQI_ERROR,
    output logic EEE_100_ENABLE,
    output logic [3:0] PULSE_AMPLITUDE
);
    pmx_pkg::pmx_access_ctrl_t ctrl_r;
    pmx_pkg::pmx_partner_cap_t partner_r;
    logic [15:0] adv_r;
    logic [15:0] pulse_r;
    logic [6:0] sqi_r;
    logic [15:0] rdata_r;
    logic rd_valid_r;
    logic [15:0] ptr;
    logic wr_ok;
    logic rd_ok;
    logic ctrl_wr;
    logic data_wr;
    logic data_rd;
    logic data_mode;
    logic ptr_load;
    logic ptr_incr;

    // Address decode of an extension register, shared by writes and reads
    function automatic logic ext_hit(input logic [4:0] dev, input logic [15:0] addr,
                                     input logic [4:0] t_dev, input logic [15:0] t_addr);
        ext_hit = (dev == t_dev) && (addr == t_addr);
    endfunction : ext_hit

    // Writes take priority; a read in the same cycle is dropped
    assign wr_ok = REG_WR;
    assign rd_ok = REG_RD && !REG_WR;
    assign ctrl_wr = wr_ok && (REG_ADDR == `PMX_PORTAL_CTRL_ADDR);
    assign data_wr = wr_ok && (REG_ADDR == `PMX_PORTAL_DATA_ADDR);
    assign data_rd = rd_ok && (REG_ADDR == `PMX_PORTAL_DATA_ADDR);
    assign data_mode = (ctrl_r.func != pmx_pkg::PMX_FN_ADDRESS);
    assign ptr_load = data_wr && !data_mode;
    assign ptr_incr = (data_wr && ((ctrl_r.func == pmx_pkg::PMX_FN_DATA_INC_RW) ||
                                   (ctrl_r.func == pmx_pkg::PMX_FN_DATA_INC_WR))) ||
                      (data_rd && (ctrl_r.func == pmx_pkg::PMX_FN_DATA_INC_RW));

    pmx_ptr_file u_ptr_file (
        .clk(CORE_CLK),
        .reset(RESET),
        .sel(ctrl_r.dev_sel),
        .load(ptr_load),
        .load_data(REG_WDATA),
        .incr(ptr_incr),
        .ptr(ptr)
    );

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ctrl_r <= `PMX_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            adv_r <= `PMX_ADV_RESET;
        end else if (data_wr && data_mode &&
                     ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER, `PMX_REG_ADVERTISE)) begin
            // Gigabit bit is never stored since that mode does not exist here
            adv_r <= REG_WDATA & `PMX_ADV_RW_MASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pulse_r <= `PMX_PULSE_RESET;
        end else if (data_wr && data_mode &&
                     ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_FRONT_END, `PMX_REG_PULSE_CTRL)) begin
            pulse_r <= REG_WDATA;
        end
    end

    // Link-down clear wins over a capability update in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            partner_r <= 2'h0;
        end else if (!LINK_UP) begin
            partner_r <= 2'h0;
        end else if (AN_EEE_VALID) begin
            partner_r <= AN_EEE_CAP;
        end
    end

    // Quality index has no reset value; it tracks the receiver every cycle
    always_ff @(posedge CORE_CLK) begin
        sqi_r <= SQI_ERROR;
    end

    // Read data is zero between answers so a stale word never looks valid
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_r <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_ok && ((REG_ADDR == `PMX_PORTAL_CTRL_ADDR) ||
                                    (REG_ADDR == `PMX_PORTAL_DATA_ADDR));
            rdata_r <= 16'h0000;
            if (rd_ok && (REG_ADDR == `PMX_PORTAL_CTRL_ADDR)) begin
                rdata_r <= ctrl_r;
            end else if (data_rd && !data_mode) begin
                rdata_r <= ptr;
            end else if (data_rd) begin
                if (ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER, `PMX_REG_ADVERTISE)) begin
                    rdata_r <= adv_r;
                end else if (ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER,
                                     `PMX_REG_PARTNER)) begin
                    rdata_r <= {13'h0000, partner_r, 1'b0};
                end else if (ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_FRONT_END,
                                     `PMX_REG_PULSE_CTRL)) begin
                    rdata_r <= pulse_r;
                end else if (ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_QUALITY,
                                     `PMX_REG_QUALITY)) begin
                    rdata_r <= {1'b0, sqi_r, 8'h00};
                end
            end
        end
    end

    // Every top-level output is a register; these only rename
    assign REG_RDATA = rdata_r;
    assign REG_RD_VALID = rd_valid_r;
    assign EEE_100_ENABLE = adv_r[`PMX_ADV_100_BIT];
    assign PULSE_AMPLITUDE = pulse_r[`PMX_PULSE_MSB:`PMX_PULSE_LSB];

    // Checks on the bank's own state and outputs, beside the logic they guard

    // Advertisement: gigabit bit pinned low, 100 Mb/s bit set only by software
    a_gig_adv_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !adv_r[`PMX_ADV_1000_BIT]) else $error("gigabit capability set");
    a_adv_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_wr && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER,
        `PMX_REG_ADVERTISE)) |=> (EEE_100_ENABLE == $past(REG_WDATA[1])))
        else $error("advertise write lost");
    a_adv_reset: assert property (@(posedge CORE_CLK) $past(RESET) |-> !EEE_100_ENABLE)
        else $error("capability not cleared by reset");
    a_adv_read_mask: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_rd && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER,
        `PMX_REG_ADVERTISE)) |=> (REG_RDATA[15:8] == 8'h00 && !REG_RDATA[`PMX_ADV_1000_BIT]))
        else $error("advertise reserved bits set");
    a_adv_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !(data_wr && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER,
        `PMX_REG_ADVERTISE)) |=> $stable(adv_r)) else $error("advertisement moved");

    // Partner capability: cleared by reset and link-down, loaded on exchange
    a_partner_down: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !LINK_UP |=> (partner_r == 2'h0)) else $error("partner bits kept");
    a_partner_load: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (LINK_UP && AN_EEE_VALID) |=> (partner_r == $past(AN_EEE_CAP)))
        else $error("partner update missed");
    a_partner_reset: assert property (@(posedge CORE_CLK)
        $past(RESET) |-> (partner_r == 2'h0)) else $error("partner bits survive reset");
    a_partner_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_rd && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_LOW_POWER,
        `PMX_REG_PARTNER)) |=> (REG_RDATA == {13'h0000, $past(partner_r), 1'b0}))
        else $error("partner bits misplaced");
    a_partner_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (LINK_UP && !AN_EEE_VALID) |=> $stable(partner_r)) else $error("partner bits moved");

    // Front-end pulse amplitude: small pulse after reset, then software's choice
    a_pulse_reset: assert property (@(posedge CORE_CLK)
        $past(RESET) |-> PULSE_AMPLITUDE == 4'h2) else $error("pulse amplitude reset wrong");
    a_pulse_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_wr && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_FRONT_END,
        `PMX_REG_PULSE_CTRL)) |=>
        (PULSE_AMPLITUDE == $past(REG_WDATA[`PMX_PULSE_MSB:`PMX_PULSE_LSB])))
        else $error("pulse amplitude write lost");
    a_pulse_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !(data_wr && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_FRONT_END,
        `PMX_REG_PULSE_CTRL)) |=> $stable(pulse_r)) else $error("pulse control moved");

    // Quality index: placed in bits 14:8 and copied from the receiver metric
    a_sqi_field: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_rd && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_QUALITY,
        `PMX_REG_QUALITY)) |=> (REG_RD_VALID && REG_RDATA[7:0] == 8'h00 && !REG_RDATA[15]))
        else $error("quality field misplaced");
    a_sqi_value: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_rd && data_mode && ext_hit(ctrl_r.dev_sel, ptr, `PMX_DEV_QUALITY,
        `PMX_REG_QUALITY)) |=> (REG_RDATA[`PMX_SQI_MSB:`PMX_SQI_LSB] == $past(SQI_ERROR, 2)))
        else $error("quality index not reported");

    // Portals: the pointer moves only on a load or a post-increment
    a_ptr_incr: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (ptr_incr && !ctrl_wr) |=> (ptr == $past(ptr) + 16'h0001))
        else $error("pointer did not advance");
    a_ptr_load: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (ptr_load) |=> (ptr == $past(REG_WDATA))) else $error("pointer not loaded");
    a_ptr_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!ptr_load && !ptr_incr && !ctrl_wr) |=> $stable(ptr))
        else $error("pointer moved unasked");
    a_ctrl_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !ctrl_wr |=> $stable(ctrl_r)) else $error("access control moved unasked");
    a_ptr_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (data_rd && !data_mode) |=> (REG_RD_VALID && REG_RDATA == $past(ptr)))
        else $error("pointer not returned");

    // Read answer: one pulse per portal read, zero data between answers
    a_rd_answer: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (rd_ok && ((REG_ADDR == `PMX_PORTAL_CTRL_ADDR) || (REG_ADDR == `PMX_PORTAL_DATA_ADDR)))
        |=> REG_RD_VALID) else $error("portal read not answered");
    a_rd_quiet: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !REG_RD_VALID |-> (REG_RDATA == 16'h0000)) else $error("read data left standing");

endmodule : pmx_ext_regs

// File: pmx_mgmt_model.sv
// Management controller model issuing one-cycle register port accesses.
// Assumes the port takes requests on the rising clock edge.
`timescale 1ns/1ns
module pmx_mgmt_model (
    input wire logic clk,
    output logic wr,
    output logic rd,
    output logic [4:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rd_valid
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h1F;
        wdata = 16'h0000;
    end
    // Released address and data lines show the inverse, strobes drop low, so a stale value never passes
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                       output logic v, output logic [15:0] q);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a;
        wdata = ~d;
        v = rd_valid;
        q = rdata;
    endtask : acc
endmodule : pmx_mgmt_model

// File: testbench.sv
// Self-checking bench for the extension register bank.
// Assumes the management model file and the design files are compiled first.
`timescale 1ns/1ns
module testbench;
    logic clk, rst, lnk, anv, wr, rd, vld, en, v;
    pmx_pkg::pmx_partner_cap_t cap;
    logic [6:0] signal_quality_index;
    logic [4:0] addr;
    logic [15:0] wd, rdat, q;
    logic [3:0] amp;
    int mismatches = 0;
    int check_count = 0;
    pmx_ext_regs i_pmx_ext_regs (.CORE_CLK(clk), .RESET(rst), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RD_VALID(vld),
        .LINK_UP(lnk), .AN_EEE_VALID(anv), .AN_EEE_CAP(cap), .SQI_ERROR(signal_quality_index),
        .EEE_100_ENABLE(en), .PULSE_AMPLITUDE(amp));
    pmx_mgmt_model i_pmx_mgmt_model (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wd), .rdata(rdat), .rd_valid(vld));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic w(input logic [4:0] a, input logic [15:0] d);
        i_pmx_mgmt_model.acc(1'b1, a, d, v, q);
    endtask : w
    task automatic rc(input string n, input logic [4:0] a, input logic [15:0] e);
        i_pmx_mgmt_model.acc(1'b0, a, 16'h0000, v, q);
        chk(n, {v, q}, {1'b1, e});
    endtask : rc
    task automatic sel(input logic [4:0] dv, input logic [15:0] ra, input logic [1:0] fn);
        w(5'h0D, {11'h000, dv});
        w(5'h0E, ra);
        w(5'h0D, {fn, 9'h000, dv});
    endtask : sel
    task automatic neg(input logic [1:0] c);
        @(posedge clk);
        #1;
        lnk = 1'b1;
        anv = 1'b1;
        cap = c;
        @(posedge clk);
        #1;
        anv = 1'b0;
        cap = ~c;
    endtask : neg
    task automatic end_of_test;
        $display("Mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        lnk = 1'b0;
        anv = 1'b0;
        cap = 2'h0;
        signal_quality_index = 7'h05;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("amp", {13'h0000, amp}, 17'h00002);
        chk("en", {16'h0000, en}, 17'h00000);
        sel(5'h07, 16'h003C, 2'h1);
        rc("adv", 5'h0E, 16'h0000);
        w(5'h0E, 16'hFFFF);
        rc("adv", 5'h0E, 16'h00FB);
        chk("en", {16'h0000, en}, 17'h00001);
        sel(5'h07, 16'h003D, 2'h1);
        rc("lp", 5'h0E, 16'h0000);
        neg(2'h3);
        rc("lp", 5'h0E, 16'h0006);
        neg(2'h1);
        rc("lp", 5'h0E, 16'h0002);
        lnk = 1'b0;
        rc("lp", 5'h0E, 16'h0000);
        sel(5'h1B, 16'h0000, 2'h1);
        rc("pulse", 5'h0E, 16'h0020);
        w(5'h0E, 16'h0070);
        chk("amp", {13'h0000, amp}, 17'h00007);
        sel(5'h1C, 16'h00AC, 2'h1);
        rc("sqi", 5'h0E, 16'h0500);
        signal_quality_index = 7'h7F;
        rc("sqi", 5'h0E, 16'h7F00);
        sel(5'h07, 16'h003C, 2'h2);
        rc("inc", 5'h0E, 16'h00FB);
        rc("inc", 5'h0E, 16'h0000);
        sel(5'h07, 16'h003C, 2'h3);
        rc("winc", 5'h0E, 16'h00FB);
        rc("winc", 5'h0E, 16'h00FB);
        w(5'h0E, 16'h0000);
        chk("en", {16'h0000, en}, 17'h00000);
        w(5'h0D, 16'h0007);
        rc("ctrl", 5'h0D, 16'h0007);
        rc("ptr", 5'h0E, 16'h003D);
        w(5'h0D, 16'h001B);
        rc("ptr", 5'h0E, 16'h0000);
        sel(5'h07, 16'h003C, 2'h1);
        w(5'h0E, 16'h0002);
        chk("en", {16'h0000, en}, 17'h00001);
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        chk("en", {16'h0000, en}, 17'h00000);
        chk("amp", {13'h0000, amp}, 17'h00002);
        i_pmx_mgmt_model.acc(1'b0, 5'h00, 16'h0000, v, q);
        chk("unmapped", {16'h0000, v}, 17'h00000);
        end_of_test();
    end
endmodule : testbench
